/* File: utf_pkg.sv */
package utf_pkg;

	// Register byte offsets, one aligned 32-bit word each.
	localparam logic [7:0] ADDR_TX_FIFO    = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_CONTROL    = 8'h08;
	localparam logic [7:0] ADDR_FIFO_CTRL  = 8'h0c;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK   = 8'h14;

	// Field positions.
	localparam int STS_TRANSMIT_END_FLAG_BIT   = 6;
	localparam int STS_TX_BELOW_TRIGGER_FLAG_BIT   = 5;
	localparam int CTL_TE_BIT     = 5;
	localparam int FCR_TRG_HI_BIT = 5;
	localparam int FCR_TRG_LO_BIT = 4;
	localparam int CNT_LSB        = 8;
	localparam int INT_TRANSMIT_END_FLAG_BIT   = 0;
	localparam int INT_TX_BELOW_TRIGGER_FLAG_BIT   = 1;

	// Reset values.
	localparam logic       RST_TRANSMIT_END_FLAG = 1'b1;
	localparam logic       RST_TX_BELOW_TRIGGER_FLAG = 1'b1;
	localparam logic       RST_TE   = 1'b0;
	localparam logic [1:0] RST_TRG  = 2'h0;

	// FIFO geometry.
	localparam int         FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_FULL  = 5'h10;

	// Trigger levels selected by the two trigger-select bits.
	localparam logic [4:0] TRG_LEVEL_0 = 5'h08;
	localparam logic [4:0] TRG_LEVEL_1 = 5'h04;
	localparam logic [4:0] TRG_LEVEL_2 = 5'h02;
	localparam logic [4:0] TRG_LEVEL_3 = 5'h01;

	// Serial timing: one start, eight data, one stop bit.
	localparam longint     CLK_HZ     = 125000000;
	localparam longint     BAUD_HZ    = 115200;
	localparam logic [10:0] BIT_CYCLES = 11'(CLK_HZ / BAUD_HZ);
	localparam logic [3:0] LAST_BIT   = 4'h9;

	// APB request as seen by the register file.
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} utf_apb_req_t;

	// Transmitter state.
	typedef enum logic [0:0] {
		UTF_IDLE  = 1'b0,
		UTF_SHIFT = 1'b1
	} utf_tx_state_t;

endpackage

/* File: utf_tx_status.sv */
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps

module utf_tx_status
	import utf_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Chip standby request, asynchronous.
	input  wire logic        standby_in,
	// Serial line and interrupt.
	output logic             txd,
	output logic             irq
);

	utf_apb_req_t  req;
	utf_tx_state_t state_reg, state_next;

	logic [7:0]  fifo_mem [FIFO_DEPTH];
	logic [3:0]  wptr_reg, rptr_reg;
	logic [4:0]  count_reg, count_next;
	logic [9:0]  shift_reg;
	logic [3:0]  bitcnt_reg;
	logic [10:0] div_reg;
	logic        transmit_end_flag_reg, tx_below_trigger_flag_reg;
	logic        transmit_end_flag_armed_reg, tx_below_trigger_flag_armed_reg;
	logic        te_reg;
	logic [1:0]  trg_reg;
	logic [1:0]  ist_reg, imask_reg;
	logic        sb1_reg, sb2_reg, sb3_reg, standby_reg;
	logic        pready_reg, pslverr_reg, txd_reg, irq_reg;
	logic [31:0] prdata_reg;

	// Bundle the bus signals.
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	// Access completes in the cycle where the registered ready is high.
	wire access   = req.sel & req.enable & pready_reg;
	wire do_write = access & req.write;
	wire do_read  = access & ~req.write;

	// Address decode.
	wire hit_fifo = (req.addr == ADDR_TX_FIFO);
	wire hit_sts  = (req.addr == ADDR_STATUS);
	wire hit_ctl  = (req.addr == ADDR_CONTROL);
	wire hit_fcr  = (req.addr == ADDR_FIFO_CTRL);
	wire hit_ist  = (req.addr == ADDR_INT_STATUS);
	wire hit_imk  = (req.addr == ADDR_INT_MASK);
	wire mapped   = hit_fifo | hit_sts | hit_ctl | hit_fcr | hit_ist | hit_imk;

	// Trigger level from the two select bits.
	wire [4:0] trg_level = (trg_reg == 2'h0) ? TRG_LEVEL_0 :
	                       (trg_reg == 2'h1) ? TRG_LEVEL_1 :
	                       (trg_reg == 2'h2) ? TRG_LEVEL_2 : TRG_LEVEL_3;

	// FIFO push and pop; a write to a full FIFO is dropped.
	wire fifo_wr    = do_write & hit_fifo;
	wire fifo_empty = (count_reg == 5'h00);
	wire push       = fifo_wr & (count_reg != FIFO_FULL) & ~standby_reg;
	wire bit_tick   = (state_reg == UTF_SHIFT) & (div_reg == BIT_CYCLES - 11'h001);
	wire char_done  = bit_tick & (bitcnt_reg == LAST_BIT);
	wire start_idle = (state_reg == UTF_IDLE) & te_reg & ~fifo_empty;
	wire chain      = char_done & te_reg & ~fifo_empty;
	wire pop        = (start_idle | chain) & ~standby_reg;
	wire [7:0] pop_data = fifo_mem[rptr_reg];

	// Next fill level.
	assign count_next = count_reg + {4'h0, push} - {4'h0, pop};

	// Flag events.
	wire transmit_end_flag_event = char_done & fifo_empty & ~standby_reg;
	wire tx_below_trigger_flag_event = pop & (count_next < trg_level);
	wire tx_busy    = (state_reg == UTF_SHIFT) | ~fifo_empty;

	// Values software sees.
	wire transmit_end_flag_view = transmit_end_flag_reg & ~tx_busy;
	wire tx_below_trigger_flag_view = tx_below_trigger_flag_reg & (count_reg < trg_level);
	wire [15:0] status_view = 16'({transmit_end_flag_view, tx_below_trigger_flag_view}) << STS_TX_BELOW_TRIGGER_FLAG_BIT;

	// Flag clearing by a zero written after a one was read.
	wire sts_wr   = do_write & hit_sts;
	wire transmit_end_flag_clr = sts_wr & ~req.wdata[STS_TRANSMIT_END_FLAG_BIT] & transmit_end_flag_armed_reg;
	wire tx_below_trigger_flag_clr = sts_wr & ~req.wdata[STS_TX_BELOW_TRIGGER_FLAG_BIT] & tx_below_trigger_flag_armed_reg;

	// Flag next values, set wins over clear.
	wire transmit_end_flag_next = standby_reg | transmit_end_flag_event | (transmit_end_flag_reg & ~fifo_wr & ~transmit_end_flag_clr);
	wire tx_below_trigger_flag_next = standby_reg | tx_below_trigger_flag_event | (tx_below_trigger_flag_reg & ~tx_below_trigger_flag_clr);

	// Interrupt status, write one to clear, set wins.
	wire [1:0] ist_set   = {tx_below_trigger_flag_event, transmit_end_flag_event};
	wire [1:0] ist_clr   = (do_write & hit_ist) ? req.wdata[1:0] : 2'h0;
	wire [1:0] ist_next  = ist_set | (ist_reg & ~ist_clr);

	// Read data mux.
	wire [31:0] rd_fifo = 32'({count_reg}) << CNT_LSB;
	wire [31:0] rd_ctl  = 32'(te_reg) << CTL_TE_BIT;
	wire [31:0] rd_fcr  = 32'(trg_reg) << FCR_TRG_LO_BIT;
	wire [31:0] rd_mux  = hit_fifo ? rd_fifo :
	                      hit_sts  ? {16'h0000, status_view} :
	                      hit_ctl  ? rd_ctl :
	                      hit_fcr  ? rd_fcr :
	                      hit_ist  ? {30'h0, ist_reg} :
	                      hit_imk  ? {30'h0, imask_reg} : 32'h00000000;

	// Transmitter state transitions.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			UTF_IDLE: begin
				if (pop) begin
					state_next = UTF_SHIFT;
				end
			end
			UTF_SHIFT: begin
				if (standby_reg | (char_done & ~pop)) begin
					state_next = UTF_IDLE;
				end
			end
		endcase
	end

	// Standby synchroniser; a change counts once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sb1_reg     <= 1'b0;
			sb2_reg     <= 1'b0;
			sb3_reg     <= 1'b0;
			standby_reg <= 1'b0;
		end else begin
			sb1_reg <= standby_in;
			sb2_reg <= sb1_reg;
			sb3_reg <= sb2_reg;
			if (sb2_reg == sb3_reg) begin
				standby_reg <= sb3_reg;
			end
		end
	end

	// APB answer: ready one cycle into the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= req.sel & req.enable & ~pready_reg;
			pslverr_reg <= req.sel & req.enable & ~pready_reg & ~mapped;
			if (req.sel & req.enable & ~pready_reg & ~req.write) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	// Control registers; standby forces the enable off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			te_reg    <= RST_TE;
			trg_reg   <= RST_TRG;
			imask_reg <= 2'h0;
		end else begin
			if (standby_reg) begin
				te_reg <= RST_TE;
			end else if (do_write & hit_ctl) begin
				te_reg <= req.wdata[CTL_TE_BIT];
			end
			if (do_write & hit_fcr) begin
				trg_reg <= {req.wdata[FCR_TRG_HI_BIT], req.wdata[FCR_TRG_LO_BIT]};
			end
			if (do_write & hit_imk) begin
				imask_reg <= req.wdata[1:0];
			end
		end
	end

	// Status flags and their read-as-one arming.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_end_flag_reg       <= RST_TRANSMIT_END_FLAG;
			tx_below_trigger_flag_reg       <= RST_TX_BELOW_TRIGGER_FLAG;
			transmit_end_flag_armed_reg <= 1'b0;
			tx_below_trigger_flag_armed_reg <= 1'b0;
			ist_reg        <= 2'h0;
			irq_reg        <= 1'b0;
		end else begin
			transmit_end_flag_reg <= transmit_end_flag_next;
			tx_below_trigger_flag_reg <= tx_below_trigger_flag_next;
			if (transmit_end_flag_clr | ~transmit_end_flag_next) begin
				transmit_end_flag_armed_reg <= 1'b0;
			end else if (do_read & hit_sts & transmit_end_flag_view) begin
				transmit_end_flag_armed_reg <= 1'b1;
			end
			if (tx_below_trigger_flag_clr | ~tx_below_trigger_flag_next) begin
				tx_below_trigger_flag_armed_reg <= 1'b0;
			end else if (do_read & hit_sts & tx_below_trigger_flag_view) begin
				tx_below_trigger_flag_armed_reg <= 1'b1;
			end
			ist_reg <= ist_next;
			irq_reg <= |(ist_next & imask_reg);
		end
	end

	// FIFO storage.
	always_ff @(posedge pclk) begin
		if (push) begin
			fifo_mem[wptr_reg] <= req.wdata[7:0];
		end
	end

	// FIFO pointers and count; standby empties the FIFO.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_reg  <= 4'h0;
			rptr_reg  <= 4'h0;
			count_reg <= 5'h00;
		end else if (standby_reg) begin
			wptr_reg  <= 4'h0;
			rptr_reg  <= 4'h0;
			count_reg <= 5'h00;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 4'h1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 4'h1;
			end
			count_reg <= count_next;
		end
	end

	// Shift register with bit-rate divider.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= UTF_IDLE;
			shift_reg  <= 10'h3ff;
			bitcnt_reg <= 4'h0;
			div_reg    <= 11'h000;
			txd_reg    <= 1'b1;
		end else begin
			state_reg <= state_next;
			if (pop) begin
				shift_reg  <= {1'b1, pop_data, 1'b0};
				bitcnt_reg <= 4'h0;
				div_reg    <= 11'h000;
			end else if (bit_tick) begin
				shift_reg  <= {1'b1, shift_reg[9:1]};
				bitcnt_reg <= bitcnt_reg + 4'h1;
				div_reg    <= 11'h000;
			end else if (state_reg == UTF_SHIFT) begin
				div_reg <= div_reg + 11'h001;
			end
			txd_reg <= (state_next == UTF_SHIFT) ? (pop ? 1'b0 : (bit_tick ? shift_reg[1] : shift_reg[0])) : 1'b1;
		end
	end

	// Registered outputs.
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata  = prdata_reg;
	assign txd     = txd_reg;
	assign irq     = irq_reg;

endmodule // utf_tx_status

/* File: utf_tx_status_checker.sv */
`timescale 1ns/100ps
// Watches the APB answers and the minimum length of each run of txd, outside standby.
module utf_tx_status_checker
	import utf_pkg::*;
(
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// APB.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Serial side.
	input wire logic        standby_in,
	input wire logic        txd
);
	logic [10:0] run_reg;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since txd last changed, saturating; reset and standby count as a long idle line,
	// so the first start bit after either is not mistaken for a short bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) run_reg <= 11'h7ff;
		else if (standby_in) run_reg <= 11'h7ff;
		else if (txd != $past(txd)) run_reg <= '0;
		else if (run_reg != 11'h7ff) run_reg <= run_reg + 11'h1;
	end
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && !pready ##1 psel && penable && pready; endsequence
	property p_wait; s_setup ##1 psel && penable |-> s_access; endproperty
	a_wait: assert property (p_wait) else $error("Wait state count wrong.");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("Ready longer than one cycle.");
	property p_in_access; pready |-> psel && penable; endproperty
	a_in_access: assert property (p_in_access) else $error("Ready outside access.");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("Error without ready.");
	property p_unmapped; pready && paddr > 8'h14 |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");
	property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("Refused read not zero.");
	property p_rd_hold; !(psel && penable && !pwrite) |=> $stable(prdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("Read data moved.");
	property p_bit_len; txd != $past(txd) && !standby_in |-> run_reg >= BIT_CYCLES - 11'h2; endproperty
	a_bit_len: assert property (p_bit_len) else $error("Serial bit too short.");
endmodule // utf_tx_status_checker

/* File: utf_rx_model.sv */
`timescale 1ns/100ps
// Remote receiver: samples mid-bit, drops false starts, LSB first.
module utf_rx_model
	import utf_pkg::*;
(
	input wire logic  pclk,
	input wire logic  txd,
	output logic [7:0] rx_byte,
	output logic      rx_stop,
	output logic [7:0] rx_cnt
);
	initial begin
		rx_byte = 8'h00;
		rx_stop = 1'b1;
		rx_cnt = 8'h00;
		forever begin
			do @(posedge pclk); while (txd !== 1'b0);
			repeat (BIT_CYCLES / 2) @(posedge pclk);
			if (txd !== 1'b0) continue;
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge pclk);
				rx_byte[i] = txd;
			end
			repeat (BIT_CYCLES) @(posedge pclk);
			rx_stop = txd;
			rx_cnt = rx_cnt + 8'h1;
		end
	end
endmodule // utf_rx_model

/* File: utf_tx_status_tb.sv */
`timescale 1ns/100ps
module utf_tx_status_tb import utf_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby_in = 0, err;
	logic [7:0]  paddr = 0, b;
	logic [31:0] pwdata = 0, rd;
	logic [7:0]  sent[$];
	wire logic pready, pslverr, txd, irq, rx_stop;
	wire logic [31:0] prdata;
	wire logic [7:0]  rx_byte, rx_cnt;
	int error_cnt = 0, compares = 0, cyc = 0;
	always #4 pclk = ~pclk;
	utf_tx_status uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .standby_in, .txd, .irq);
	utf_rx_model rx (.pclk, .txd, .rx_byte, .rx_stop, .rx_cnt);
	// Expected status bits from the two flags.
	function automatic logic [31:0] sts(logic e, logic t);
		return (32'(e) << STS_TRANSMIT_END_FLAG_BIT) | (32'(t) << STS_TX_BELOW_TRIGGER_FLAG_BIT);
	endfunction
	task chk(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task end_sim;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rs(logic [31:0] e);
		apb(0, ADDR_STATUS, 0);
		chk("status", e, rd & 32'h60);
	endtask
	task rc(logic [31:0] e);
		apb(0, ADDR_TX_FIFO, 0);
		chk("count", e, 32'(rd[15:8]));
	endtask
	// Each received frame must match the next byte sent.
	always @(rx_cnt) if (rx_cnt != 0) begin
		chk("rx byte", sent.pop_front(), rx_byte);
		chk("stop", 1, rx_stop);
	end
	// Hang guard.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			error_cnt++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(32'hca4f8566));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(1, ADDR_STATUS, 0);
		rs(sts(1, 1));
		apb(1, ADDR_STATUS, 32'h60);
		rs(sts(1, 1));
		apb(1, ADDR_STATUS, 0);
		rs(sts(0, 0));
		rc(0);
		apb(0, 8'h20, 0);
		chk("slverr", 1, err);
		chk("rdata", 0, rd);
		for (int n = 0; n < 17; n++) apb(1, ADDR_TX_FIFO, 32'(8'($urandom)));
		rc(16);
		rs(sts(0, 0));
		apb(1, ADDR_CONTROL, 32'h20);
		@(posedge pclk) standby_in <= 1;
		repeat (8) @(posedge pclk);
		standby_in <= 0;
		repeat (8) @(posedge pclk);
		rc(0);
		rs(sts(1, 1));
		apb(0, ADDR_CONTROL, 0);
		chk("enable", 0, 32'(rd[CTL_TE_BIT]));
		apb(1, ADDR_FIFO_CTRL, 32'h20);
		for (int n = 0; n < 3; n++) begin
			b = 8'($urandom);
			sent.push_back(b);
			apb(1, ADDR_TX_FIFO, 32'(b));
		end
		apb(1, ADDR_STATUS, 0);
		apb(1, ADDR_INT_STATUS, 3);
		apb(1, ADDR_INT_MASK, 1);
		apb(1, ADDR_CONTROL, 32'h20);
		rs(sts(0, 0));
		do apb(0, ADDR_TX_FIFO, 0); while (rd[15:8] !== 8'h01);
		rs(sts(0, 1));
		chk("irq masked", 0, 32'(irq));
		do apb(0, ADDR_STATUS, 0); while (rd[STS_TRANSMIT_END_FLAG_BIT] !== 1'b1);
		apb(0, ADDR_INT_STATUS, 0);
		chk("int status", 3, rd & 32'h3);
		repeat (2) @(posedge pclk);
		chk("irq", 1, 32'(irq));
		chk("frames", 3, 32'(rx_cnt));
		apb(1, ADDR_INT_STATUS, 1);
		repeat (2) @(posedge pclk);
		chk("irq clear", 0, 32'(irq));
		end_sim();
	end
endmodule // utf_tx_status_tb
bind utf_tx_status utf_tx_status_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pready, .prdata, .pslverr, .standby_in, .txd);
